// >>> vcd_pkg.sv
`default_nettype none
package vcd_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] VCD_OFS_CMD    = 12'h000;
  localparam logic [11:0] VCD_OFS_ACRD   = 12'h004;
  localparam logic [11:0] VCD_OFS_DATA   = 12'h008;
  localparam logic [11:0] VCD_OFS_STATUS = 12'h00C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int VCD_CMD_RS_BIT = 8;
  localparam int VCD_BUSY_BIT   = 7;

  // ---------------------------------------------------------------
  // reset values and geometry
  // ---------------------------------------------------------------
  localparam logic [7:0] VCD_SPACE_CODE = 8'h20;
  localparam logic [6:0] VCD_AC_RESET   = 7'h00;
  localparam logic [6:0] VCD_LINE1_BASE = 7'h40;
  localparam logic [5:0] VCD_LINE_LEN   = 6'h28;
  localparam int         VCD_TEXT_DEPTH  = 128;
  localparam int         VCD_GLYPH_DEPTH = 64;
  localparam logic [1:0] VCD_BRIGHT_100 = 2'h0;
  localparam logic [1:0] VCD_BRIGHT_75  = 2'h1;
  localparam logic [1:0] VCD_BRIGHT_50  = 2'h2;
  localparam logic [1:0] VCD_BRIGHT_25  = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint VCD_CLK_PERIOD_NS  = 25;
  localparam longint VCD_BLINK_HALF_NS  = 500000000;
  localparam longint VCD_BLINK_HALF_CYC = VCD_BLINK_HALF_NS / VCD_CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    VCD_TGT_TEXT  = 1'b0,
    VCD_TGT_GLYPH = 1'b1
  } vcd_target_t;

  typedef struct packed {
    logic       increment_select;
    logic       shift_on_write;
    logic       display_on_bit;
    logic       cursor_on_bit;
    logic       blink_bit;
    logic       bus_width_bit;
    logic       line_count_bit;
    logic [1:0] brightness_field;
  } vcd_cfg_t;

  localparam vcd_cfg_t VCD_CFG_RESET = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0};

  typedef struct packed {
    logic [4:0] position;
    logic [7:0] code;
    logic       visible;
    logic       cursor_row;
    logic       all_on;
  } vcd_scan_t;

endpackage
`default_nettype wire

// >>> vcd_char_command_decoder.sv
`default_nettype none
//
// Behaviour
// - bit3-top instruction loads display, cursor, blink bits only
// - display off blanks screen; on shows text RAM
// - cursor on lights eighth pixel row at cursor position
// - blink alternates cursor character with all-on, about 1 Hz, half duty
// - bit4-top instruction steps counter per direction, no RAM access
// - with shift select, whole image moves one character
// - cursor shift instruction makes counter target text RAM
// - bit5-top instruction sets 4-bit or 8-bit bus width
// - brightness field selects 100, 75, 50 or 25 percent
// - bit6-top instruction loads 6-bit address, targets glyph RAM
// - bit7 instruction loads 7-bit address, targets text RAM
// - instruction read returns counter and busy bit zero
// - every byte accepted at full rate, never busy
// - data write stores byte at counter in selected RAM
// - after data write counter steps and display may shift
// - data read returns byte at counter then steps counter
// - reset fills text RAM with spaces, counter 00H, unshifted
// - reset sets entry, control and function defaults
// - settings instructions leave RAM and counter alone
// - decrement shifts right, increment shifts left on write
module vcd_char_command_decoder #(
  parameter longint BLINK_HALF_CYCLES = vcd_pkg::VCD_BLINK_HALF_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output vcd_pkg::vcd_cfg_t     cfg_out,
  output vcd_pkg::vcd_scan_t    scan_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] vcd_step(input logic [6:0] ac, input logic up);
    vcd_step = up ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
  endfunction

  // offset counts how far the image has moved left, modulo a line
  function automatic logic [5:0] vcd_shift(input logic [5:0] off, input logic left);
    logic [5:0] r;
    r = '0;
    if (left)
    begin
      r = (off == 6'(vcd_pkg::VCD_LINE_LEN - 6'h01)) ? 6'h00 : 6'(off + 6'h01);
    end
    else
    begin
      r = (off == 6'h00) ? 6'(vcd_pkg::VCD_LINE_LEN - 6'h01) : 6'(off - 6'h01);
    end
    vcd_shift = r;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  vcd_pkg::vcd_cfg_t    cfg_reg;
  vcd_pkg::vcd_cfg_t    cfg_next;
  vcd_pkg::vcd_target_t target_reg;
  vcd_pkg::vcd_target_t target_next;
  logic [6:0]           ac_reg;
  logic [6:0]           ac_next;
  logic [5:0]           offset_reg;
  logic [5:0]           offset_next;
  logic [7:0]           text_mem [vcd_pkg::VCD_TEXT_DEPTH];
  logic [7:0]           glyph_mem [vcd_pkg::VCD_GLYPH_DEPTH];
  logic [31:0]          prdata_reg;
  logic [31:0]          prdata_next;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic                 pslverr_next;
  logic [31:0]          blink_cnt_reg;
  logic                 blink_phase_reg;
  logic [4:0]           scan_pos_reg;
  vcd_pkg::vcd_scan_t   scan_reg;
  vcd_pkg::vcd_scan_t   scan_next;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        setup_phase = psel && !penable;
  wire        access      = psel && penable && pready_reg;
  wire        hit_cmd     = (paddr == vcd_pkg::VCD_OFS_CMD);
  wire        hit_acrd    = (paddr == vcd_pkg::VCD_OFS_ACRD);
  wire        hit_data    = (paddr == vcd_pkg::VCD_OFS_DATA);
  wire        hit_status  = (paddr == vcd_pkg::VCD_OFS_STATUS);
  wire        hit_any     = hit_cmd || hit_acrd || hit_data || hit_status;
  // only the command word is writable; the read ports refuse writes
  wire        bad_access  = !hit_any || (pwrite && !hit_cmd);
  wire        wr_fire     = access && pwrite && hit_cmd;
  wire        rd_data     = access && !pwrite && hit_data;
  wire [7:0]  wbyte       = pwdata[7:0];
  wire        wr_rs       = pwdata[vcd_pkg::VCD_CMD_RS_BIT];
  wire        is_instr    = wr_fire && !wr_rs;
  wire        is_dwrite   = wr_fire && wr_rs;
  wire        op_entry    = is_instr && (wbyte[7:2] == 6'h01);
  wire        op_ctrl     = is_instr && (wbyte[7:3] == 5'h01);
  wire        op_shift    = is_instr && (wbyte[7:4] == 4'h1);
  wire        op_func     = is_instr && (wbyte[7:5] == 3'h1);
  wire        op_cgset    = is_instr && (wbyte[7:6] == 2'h1);
  wire        op_ddset    = is_instr && wbyte[7];
  wire        tgt_glyph   = (target_reg == vcd_pkg::VCD_TGT_GLYPH);
  wire [7:0]  ram_rd      = tgt_glyph ? glyph_mem[ac_reg[5:0]] : text_mem[ac_reg];
  wire [31:0] ac_word     = {24'h000000, 1'b0, ac_reg}; // busy bit is bit 7, never set
  wire [31:0] status_word = {16'h0000, offset_reg, target_reg, cfg_reg};

  // ---------------------------------------------------------------
  // instruction and data execution
  // ---------------------------------------------------------------
  always_comb
  begin
    cfg_next    = cfg_reg;
    target_next = target_reg;
    ac_next     = ac_reg;
    offset_next = offset_reg;
    if (op_ddset)
    begin
      ac_next     = wbyte[6:0];
      target_next = vcd_pkg::VCD_TGT_TEXT;
    end
    else if (op_cgset)
    begin
      ac_next     = {1'b0, wbyte[5:0]};
      target_next = vcd_pkg::VCD_TGT_GLYPH;
    end
    else if (op_func)
    begin
      cfg_next.bus_width_bit    = wbyte[4];
      cfg_next.line_count_bit   = wbyte[3];
      cfg_next.brightness_field = wbyte[1:0];
    end
    else if (op_shift)
    begin
      ac_next     = vcd_step(ac_reg, wbyte[2]);
      target_next = vcd_pkg::VCD_TGT_TEXT;
      if (wbyte[3])
      begin
        offset_next = vcd_shift(offset_reg, !wbyte[2]);
      end
    end
    else if (op_ctrl)
    begin
      cfg_next.display_on_bit = wbyte[2];
      cfg_next.cursor_on_bit  = wbyte[1];
      cfg_next.blink_bit      = wbyte[0];
    end
    else if (op_entry)
    begin
      cfg_next.increment_select = wbyte[1];
      cfg_next.shift_on_write   = wbyte[0];
    end
    else if (is_dwrite)
    begin
      ac_next = vcd_step(ac_reg, cfg_reg.increment_select);
      if (cfg_reg.shift_on_write && !tgt_glyph)
      begin
        offset_next = vcd_shift(offset_reg, cfg_reg.increment_select);
      end
    end
    else if (rd_data)
    begin
      ac_next = vcd_step(ac_reg, cfg_reg.increment_select);
    end
  end

  // zero-wait answer: prepared in setup, valid in the access phase
  assign prdata_next  = !setup_phase ? 32'h00000000 :
                        hit_acrd     ? ac_word :
                        hit_data     ? {24'h000000, ram_rd} :
                        hit_status   ? status_word : 32'h00000000;
  assign pslverr_next = setup_phase && bad_access;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg     <= vcd_pkg::VCD_CFG_RESET;
      target_reg  <= vcd_pkg::VCD_TGT_TEXT;
      ac_reg      <= vcd_pkg::VCD_AC_RESET;
      offset_reg  <= 6'h00;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      cfg_reg     <= cfg_next;
      target_reg  <= target_next;
      ac_reg      <= ac_next;
      offset_reg  <= offset_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= setup_phase;
      pslverr_reg <= pslverr_next;
    end
  end

  // ---------------------------------------------------------------
  // character memories
  // ---------------------------------------------------------------
  // text memory resets in flops: a space fill needs no sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < vcd_pkg::VCD_TEXT_DEPTH; i++)
      begin
        text_mem[i] <= vcd_pkg::VCD_SPACE_CODE;
      end
    end
    else if (is_dwrite && !tgt_glyph)
    begin
      text_mem[ac_reg] <= wbyte;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < vcd_pkg::VCD_GLYPH_DEPTH; i++)
      begin
        glyph_mem[i] <= 8'h00;
      end
    end
    else if (is_dwrite && tgt_glyph)
    begin
      glyph_mem[ac_reg[5:0]] <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // blink timer and screen scan
  // ---------------------------------------------------------------
  wire        blink_wrap = (blink_cnt_reg == 32'(BLINK_HALF_CYCLES - 1));
  wire        scan_line  = scan_pos_reg[4];
  wire [5:0]  col_sum    = 6'({2'b00, scan_pos_reg[3:0]} + offset_reg);
  wire [5:0]  col_wrap   = (col_sum >= vcd_pkg::VCD_LINE_LEN) ?
                           6'(col_sum - vcd_pkg::VCD_LINE_LEN) : col_sum;
  wire [6:0]  scan_addr  = 7'((scan_line ? vcd_pkg::VCD_LINE1_BASE : 7'h00) + {1'b0, col_wrap});
  wire        at_cursor  = !tgt_glyph && (ac_reg == scan_addr);
  wire        disp_on    = cfg_reg.display_on_bit;

  always_comb
  begin
    scan_next            = '0;
    scan_next.position   = scan_pos_reg;
    scan_next.code       = disp_on ? text_mem[scan_addr] : vcd_pkg::VCD_SPACE_CODE;
    scan_next.visible    = disp_on;
    scan_next.cursor_row = disp_on && cfg_reg.cursor_on_bit && at_cursor;
    scan_next.all_on     = disp_on && cfg_reg.blink_bit && blink_phase_reg && at_cursor;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt_reg   <= 32'h00000000;
      blink_phase_reg <= 1'b0;
      scan_pos_reg    <= 5'h00;
      scan_reg        <= '0;
    end
    else
    begin
      blink_cnt_reg   <= blink_wrap ? 32'h00000000 : 32'(blink_cnt_reg + 32'h00000001);
      blink_phase_reg <= blink_wrap ? !blink_phase_reg : blink_phase_reg;
      scan_pos_reg    <= 5'(scan_pos_reg + 5'h01);
      scan_reg        <= scan_next;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign cfg_out  = cfg_reg;
  assign scan_out = scan_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ctrl_load_bits: assert property (op_ctrl |=>
    (cfg_reg.display_on_bit == $past(pwdata[2])) && (cfg_reg.cursor_on_bit == $past(pwdata[1]))
    && (cfg_reg.blink_bit == $past(pwdata[0])) && (ac_reg == $past(ac_reg)))
    else $error("control instruction did not load bits");

  a_shift_step_up: assert property (op_shift && pwdata[2] |=>
    ac_reg == 7'($past(ac_reg) + 7'h01))
    else $error("cursor shift did not step counter up");

  a_shift_step_down: assert property (op_shift && !pwdata[2] |=>
    ac_reg == 7'($past(ac_reg) - 7'h01))
    else $error("cursor shift did not step counter down");

  a_shift_keep_image: assert property (op_shift && !pwdata[3] |=>
    $stable(offset_reg))
    else $error("cursor-only shift moved the image");

  a_shift_move_image: assert property (op_shift && pwdata[3] |=>
    !$stable(offset_reg))
    else $error("display shift left the image in place");

  a_shift_to_text: assert property (op_shift |=>
    target_reg == vcd_pkg::VCD_TGT_TEXT)
    else $error("cursor shift left glyph target");

  a_func_width: assert property (op_func |=>
    cfg_reg.bus_width_bit == $past(pwdata[4]))
    else $error("bus width not loaded");

  a_func_bright: assert property (op_func |=>
    cfg_reg.brightness_field == $past(pwdata[1:0]))
    else $error("brightness not loaded");

  a_cgset_addr: assert property (op_cgset |=>
    (ac_reg == {1'b0, $past(pwdata[5:0])}) && tgt_glyph)
    else $error("glyph address set failed");

  a_ddset_addr: assert property (op_ddset |=>
    (ac_reg == $past(pwdata[6:0])) && !tgt_glyph)
    else $error("text address set failed");

  a_acrd_value: assert property (setup_phase && hit_acrd && !pwrite |=>
    prdata == {24'h000000, 1'b0, ac_reg})
    else $error("counter read value wrong");

  a_never_busy: assert property (setup_phase |=>
    pready ##1 !pready || (psel && !penable))
    else $error("slave did not answer in one cycle");

  a_dwrite_store: assert property (is_dwrite && !tgt_glyph |=>
    text_mem[$past(ac_reg)] == $past(pwdata[7:0]))
    else $error("text data write not stored");

  a_glyph_store: assert property (is_dwrite && tgt_glyph |=>
    glyph_mem[$past(ac_reg[5:0])] == $past(pwdata[7:0]))
    else $error("glyph data write not stored");

  a_dwrite_step: assert property (is_dwrite && cfg_reg.increment_select |=>
    ac_reg == 7'($past(ac_reg) + 7'h01))
    else $error("data write did not step counter");

  a_glyph_no_shift: assert property (is_dwrite && tgt_glyph |=>
    $stable(offset_reg))
    else $error("glyph write shifted the display");

  a_dread_step: assert property (rd_data && cfg_reg.increment_select |=>
    ac_reg == 7'($past(ac_reg) + 7'h01))
    else $error("data read did not step counter");

  a_access_dec: assert property ((is_dwrite || rd_data) && !cfg_reg.increment_select |=>
    ac_reg == 7'($past(ac_reg) - 7'h01))
    else $error("data access did not decrement counter");

  a_func_keeps_ac: assert property (op_func || op_ctrl |=>
    $stable(ac_reg))
    else $error("settings instruction moved counter");

  a_blank_off: assert property (rst_n && !cfg_reg.display_on_bit |=>
    !scan_out.visible && (scan_out.code == vcd_pkg::VCD_SPACE_CODE))
    else $error("screen not blank with display off");

  a_cursor_off: assert property (!cfg_reg.cursor_on_bit |=>
    !scan_out.cursor_row)
    else $error("cursor drawn while cursor off");

  a_blink_off: assert property (!cfg_reg.blink_bit |=>
    !scan_out.all_on)
    else $error("blink cell shown while blink off");

endmodule // vcd_char_command_decoder
`default_nettype wire

// >>> vcd_host_model.sv
`default_nettype none
// ---------------------------------------------------------------
// host processor on the apb side
// ---------------------------------------------------------------
module vcd_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // no busy polling: each transfer goes out as soon as the last ends
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // waits as long as it takes; only the bench watchdog ends a hang
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines show garbage, not the last value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // vcd_host_model
`default_nettype wire

// >>> vcd_char_command_decoder_tb_top.sv
`default_nettype none
module vcd_char_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rv;
  logic               last_err;
  vcd_pkg::vcd_cfg_t  cfg_out, ecfg;
  vcd_pkg::vcd_scan_t scan_out, s;
  int                 err_count = 0;
  int                 check_count = 0;

  always #12.5 clk = ~clk;

  // short blink half period keeps the run small
  vcd_char_command_decoder #(.BLINK_HALF_CYCLES(40)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_out(cfg_out), .scan_out(scan_out));

  vcd_host_model host (
    .clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [8:0] v);
    host.xfer(1'b1, vcd_pkg::VCD_OFS_CMD, {23'h0, v}, rv, last_err);
    chk({31'h0, last_err}, 32'h0);
    // the write lands on the access edge: let it settle before looking
    #1;
  endtask

  task automatic exp_rd(input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rv, last_err);
    chk(rv, e);
  endtask

  task automatic scan_at(input logic [4:0] p);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (scan_out.position !== p && n < 64);
    s = scan_out;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    ecfg = vcd_pkg::VCD_CFG_RESET;
    chk({23'h0, cfg_out}, {23'h0, 9'h10C});
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h0);
    exp_rd(vcd_pkg::VCD_OFS_DATA, 32'h20);
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h1);
    exp_rd(vcd_pkg::VCD_OFS_STATUS, {23'h0, ecfg});
  endtask

  task automatic t_onoff;
    cmd(9'h087);
    cmd(9'h00F);
    ecfg.display_on_bit = 1'b1;
    ecfg.cursor_on_bit = 1'b1;
    ecfg.blink_bit = 1'b1;
    chk({23'h0, cfg_out}, {23'h0, ecfg});
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h07);
  endtask

  task automatic t_func;
    for (int k = 0; k < 8; k++)
    begin
      cmd({1'b0, 3'h1, k[2], 1'b1, 1'b0, k[1:0]});
      ecfg.bus_width_bit = k[2];
      ecfg.brightness_field = k[1:0];
      chk({23'h0, cfg_out}, {23'h0, ecfg});
      exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h07);
    end
  endtask

  task automatic t_text;
    cmd(9'h085);
    cmd(9'h141);
    cmd(9'h142);
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h07);
    cmd(9'h085);
    exp_rd(vcd_pkg::VCD_OFS_DATA, 32'h41);
    exp_rd(vcd_pkg::VCD_OFS_DATA, 32'h42);
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h07);
  endtask

  task automatic t_entry;
    cmd(9'h005);
    ecfg.increment_select = 1'b0;
    ecfg.shift_on_write = 1'b1;
    chk({23'h0, cfg_out}, {23'h0, ecfg});
    cmd(9'h090);
    cmd(9'h155);
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h0F);
    exp_rd(vcd_pkg::VCD_OFS_STATUS, {16'h0, 6'h27, 1'b0, ecfg});
    cmd(9'h007);
    ecfg.increment_select = 1'b1;
    cmd(9'h161);
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h10);
    exp_rd(vcd_pkg::VCD_OFS_STATUS, {22'h0, 1'b0, ecfg});
    cmd(9'h006);
    ecfg.shift_on_write = 1'b0;
    chk({23'h0, cfg_out}, {23'h0, ecfg});
  endtask

  task automatic t_glyph;
    cmd(9'h07F);
    exp_rd(vcd_pkg::VCD_OFS_STATUS, {22'h0, 1'b1, ecfg});
    cmd(9'h111);
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h40);
    cmd(9'h07F);
    exp_rd(vcd_pkg::VCD_OFS_DATA, 32'h11);
    cmd(9'h010);
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h3F);
    exp_rd(vcd_pkg::VCD_OFS_STATUS, {22'h0, 1'b0, ecfg});
  endtask

  task automatic t_shift;
    cmd(9'h018);
    exp_rd(vcd_pkg::VCD_OFS_STATUS, {16'h0, 6'h01, 1'b0, ecfg});
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h3E);
    cmd(9'h01C);
    cmd(9'h017);
    exp_rd(vcd_pkg::VCD_OFS_STATUS, {22'h0, 1'b0, ecfg});
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h40);
  endtask

  task automatic t_refuse;
    host.xfer(1'b1, vcd_pkg::VCD_OFS_ACRD, 32'h0, rv, last_err);
    chk({31'h0, last_err}, 32'h1);
    host.xfer(1'b0, 12'h010, 32'h0, rv, last_err);
    chk({31'h0, last_err}, 32'h1);
    exp_rd(vcd_pkg::VCD_OFS_CMD, 32'h0);
    chk({31'h0, last_err}, 32'h0);
    cmd(9'h003);
    chk({23'h0, cfg_out}, {23'h0, ecfg});
    exp_rd(vcd_pkg::VCD_OFS_ACRD, 32'h40);
  endtask

  task automatic t_scan;
    int on_n;
    int off_n;
    cmd(9'h085);
    cmd(9'h00E);
    scan_at(5'h05);
    chk({25'h0, s.code[3:0], s.visible, s.cursor_row, s.all_on}, 32'h0E);
    chk({24'h0, s.code}, 32'h41);
    scan_at(5'h06);
    chk({23'h0, s.code, s.cursor_row}, 32'h84);
    cmd(9'h008);
    scan_at(5'h05);
    chk({23'h0, s.code, s.visible}, 32'h40);
    cmd(9'h00D);
    on_n = 0;
    off_n = 0;
    for (int k = 0; k < 24; k++)
    begin
      scan_at(5'h05);
      if (s.all_on === 1'b1) on_n++;
      if (s.all_on === 1'b0) off_n++;
      chk({31'h0, s.cursor_row}, 32'h0);
    end
    chk({31'h0, on_n > 0 && off_n > 0}, 32'h1);
    // half duty: samples 32 cycles apart over a 40-cycle half period
    chk({31'h0, on_n >= 8 && on_n <= 16}, 32'h1);
    scan_at(5'h06);
    chk({31'h0, s.all_on}, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    err_count++;
    end_sim();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_onoff();
    t_func();
    t_text();
    t_entry();
    t_glyph();
    t_shift();
    t_refuse();
    t_scan();
    end_sim();
  end
endmodule // vcd_char_command_decoder_tb_top
`default_nettype wire
